// [logic/nfhc_defines.svh]
// command codes, status bit positions, split column and timing figures of the flash host controller
`ifndef NFHC_DEFINES_SVH
`define NFHC_DEFINES_SVH
`define NFHC_CMD_READ_1ST     8'h00
`define NFHC_CMD_READ_2ND     8'h30
`define NFHC_CMD_HALF_2ND     8'h20
`define NFHC_CMD_CACHE_SEQ    8'h31
`define NFHC_CMD_CACHE_LAST   8'h3f
`define NFHC_CMD_PROG_1ST     8'h80
`define NFHC_CMD_PROG_2ND     8'h10
`define NFHC_CMD_CPROG_2ND    8'h15
`define NFHC_CMD_ERASE_1ST    8'h60
`define NFHC_CMD_ERASE_2ND    8'hd0
`define NFHC_CMD_CBREAD_2ND   8'h35
`define NFHC_CMD_CBPROG_1ST   8'h85
`define NFHC_CMD_RDOUT_1ST    8'h05
`define NFHC_CMD_RDOUT_2ND    8'he0
`define NFHC_CMD_SETFEAT      8'hef
`define NFHC_CMD_GETFEAT      8'hee
`define NFHC_CMD_SETFEAT_LU   8'hd5
`define NFHC_CMD_GETFEAT_LU   8'hd4
`define NFHC_CMD_READ_ID      8'h90
`define NFHC_CMD_STATUS       8'h70
`define NFHC_CMD_RESET        8'hff
`define NFHC_CMD_RESET_LU     8'hfa
// status bit positions
`define NFHC_SR_READY_POS     6
`define NFHC_SR_ARRAY_POS     5
// half page split column
`define NFHC_HALF_SPLIT_COL   16'h1180
// clock and timing figures
`define NFHC_CLK_PERIOD_PS    10000
`define NFHC_CE_HIGH_READ_NS  35
`define NFHC_CE_HIGH_PROG_NS  125
`define NFHC_TURNAROUND_NS    120
`define NFHC_CE_HIGH_READ_CYC ((`NFHC_CE_HIGH_READ_NS*1000+`NFHC_CLK_PERIOD_PS-1)/`NFHC_CLK_PERIOD_PS)
`define NFHC_CE_HIGH_PROG_CYC ((`NFHC_CE_HIGH_PROG_NS*1000+`NFHC_CLK_PERIOD_PS-1)/`NFHC_CLK_PERIOD_PS)
`define NFHC_TURNAROUND_CYC   ((`NFHC_TURNAROUND_NS*1000+`NFHC_CLK_PERIOD_PS-1)/`NFHC_CLK_PERIOD_PS)
// write strobe phase length in core cycles
`define NFHC_WE_PHASE_CYC     3
`endif

// [logic/nfhc_host.sv]
// host sequencer driving the flash pins for commands, addresses and reads
`timescale 1ns/1ps
`default_nettype none
`include "nfhc_defines.svh"
module nfhc_host
    import nfhc_pkg::*;
#(
    parameter int COL_W  = 16,  // column address width
    parameter int ROW_W  = 24,  // row address width
    parameter int LEN_W  = 16   // read length counter width
)(
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    input  wire logic             link_clock,
    // user command port
    input  wire logic             op_valid,
    input  wire nfhc_op_t         op_code,
    input  wire logic [COL_W-1:0] op_column,
    input  wire logic [ROW_W-1:0] op_row,
    input  wire logic [LEN_W-1:0] op_length,
    input  wire logic             last_page_in_block,
    output logic                  op_ready,
    output logic                  op_refused,
    output logic                  rd_valid,
    output logic            [7:0] rd_data,
    output logic                  rd_done,
    output logic                  status_ready_bit,
    output logic                  status_array_ready_bit,
    // flash pins
    output logic                  ce_n,
    output logic                  cle,
    output logic                  ale,
    output logic                  we_n,
    output logic                  read_strobe_n,
    output logic            [7:0] dq_out,
    output logic                  dq_oe_n,
    input  wire logic       [7:0] dq_in,
    output logic                  dq_capture
);
    nfhc_state_t      state_reg;      // sequencer state
    nfhc_op_t         op_reg;         // operation in flight
    logic [7:0]       cmd2_reg;       // confirm code, zero when none
    logic [39:0]      addr_reg;       // address bytes, low first
    logic [2:0]       addr_left_reg;  // address bytes still to send
    logic [LEN_W-1:0] len_reg;        // bytes still to read
    logic [15:0]      wait_reg;       // generic delay counter
    logic [1:0]       phase_reg;      // we strobe phase
    logic             wbusy_reg;      // a pin write is in progress
    logic             cache_on_reg;   // cache read sequence open
    logic             last_prog_reg;  // last frame was a program type
    logic             gap_done_reg;   // ce high gap satisfied
    logic [15:0]      gap_reg;        // ce high counter
    logic [7:0]       sync_data;      // byte back from link domain
    logic             sync_pulse;     // one per byte back
    logic [1:0]       rd_step_reg;    // read strobe step within one byte

    // read bytes come back through the link-domain capture
    nfhc_strobe_sync u_sync (
        .link_clock (link_clock),
        .clock      (clock),
        .reset_n    (reset_n),
        .clk_en     (clk_en),
        .dq_in      (dq_in),
        .dq_capture (dq_capture),
        .data_out   (sync_data),
        .data_pulse (sync_pulse)
    );

    // legality of a new operation against the cache state and status
    function automatic logic op_legal(input nfhc_op_t op, input logic cache_on,
                                      input logic rdy, input logic ardy,
                                      input logic last_pg);
        logic ok;
        ok = 1'b1;
        if (!ardy && !(op == NFHC_OP_CACHE_SEQ || op == NFHC_OP_CACHE_LAST ||
                       op == NFHC_OP_RESET || op == NFHC_OP_STATUS))
            ok = 1'b0;
        if (op == NFHC_OP_CACHE_SEQ && (!rdy || last_pg))
            ok = 1'b0;
        if ((op == NFHC_OP_CACHE_SEQ || op == NFHC_OP_CACHE_LAST) && !cache_on)
            ok = 1'b0;
        if (op == NFHC_OP_RAND_OUT && !rdy)
            ok = 1'b0;
        return ok;
    endfunction

    // sequencer: launch, command, address, confirm, wait, read, gap
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_reg     <= NFHC_IDLE;
            op_reg        <= NFHC_OP_STATUS;
            cmd2_reg      <= 8'h00;
            addr_reg      <= 40'h0;
            addr_left_reg <= 3'h0;
            len_reg       <= '0;
            wait_reg      <= 16'h0;
            op_ready      <= 1'b0;
            op_refused    <= 1'b0;
            rd_done       <= 1'b0;
            cache_on_reg  <= 1'b0;
            last_prog_reg <= 1'b0;
        end else if (clk_en) begin
            op_refused <= 1'b0;
            rd_done    <= 1'b0;
            unique case (state_reg)
                NFHC_IDLE: begin
                    op_ready <= gap_done_reg;  // ce gap keeps the port closed
                    if (op_valid && op_ready) begin
                        op_ready <= 1'b0;
                        if (!op_legal(op_code, cache_on_reg, status_ready_bit,
                                      status_array_ready_bit, last_page_in_block)) begin
                            op_refused <= 1'b1;
                        end else begin
                            op_reg    <= op_code;
                            len_reg   <= op_length;
                            // column lsb forced to zero
                            addr_reg  <= {op_row[23:0], op_column[15:1], 1'b0};
                            state_reg <= NFHC_CMD1;
                        end
                    end
                end
                NFHC_CMD1: begin
                    if (!wbusy_reg && phase_reg == 2'h0) begin
                        unique case (op_reg)
                            NFHC_OP_PAGE_READ, NFHC_OP_HALF_READ: begin
                                addr_left_reg <= 3'h5;
                                cmd2_reg <= (op_reg == NFHC_OP_HALF_READ) ?
                                            `NFHC_CMD_HALF_2ND : `NFHC_CMD_READ_2ND;
                                cache_on_reg <= (op_reg == NFHC_OP_PAGE_READ);
                            end
                            NFHC_OP_RAND_OUT: begin
                                addr_left_reg <= 3'h2;
                                cmd2_reg      <= `NFHC_CMD_RDOUT_2ND;
                            end
                            NFHC_OP_RESET_LU: begin
                                addr_left_reg <= 3'h3;
                                addr_reg      <= {16'h0, addr_reg[39:16]};
                                cmd2_reg      <= 8'h00;
                            end
                            NFHC_OP_READ_ID: begin
                                addr_left_reg <= 3'h1;
                                addr_reg      <= 40'h0;
                                cmd2_reg      <= 8'h00;
                            end
                            NFHC_OP_CACHE_LAST, NFHC_OP_RESET: begin
                                addr_left_reg <= 3'h0;
                                cmd2_reg      <= 8'h00;
                                cache_on_reg  <= 1'b0;
                            end
                            default: begin
                                addr_left_reg <= 3'h0;
                                cmd2_reg      <= 8'h00;
                            end
                        endcase
                        state_reg <= NFHC_ADDR;
                    end
                end
                NFHC_ADDR: begin
                    if (phase_reg == 2'h0 && !wbusy_reg) begin
                        if (addr_left_reg == 3'h0) begin
                            state_reg <= (cmd2_reg != 8'h00) ? NFHC_CMD2 : NFHC_WAIT;
                            wait_reg  <= 16'(`NFHC_TURNAROUND_CYC);
                        end
                    end
                    // only address bytes count, not the command byte still going out
                    if (wbusy_reg && phase_reg == 2'h3 && ale) begin
                        addr_left_reg <= addr_left_reg - 3'h1;
                        addr_reg      <= {8'h00, addr_reg[39:8]};
                    end
                end
                NFHC_CMD2: begin
                    if (wbusy_reg && phase_reg == 2'h3) begin
                        state_reg <= NFHC_WAIT;
                        wait_reg  <= 16'(`NFHC_TURNAROUND_CYC);
                    end
                end
                NFHC_WAIT: begin
                    if (wait_reg != 16'h0) begin
                        wait_reg <= wait_reg - 16'h1;
                    end else if (len_reg != '0 && op_reg != NFHC_OP_RESET &&
                                 op_reg != NFHC_OP_RESET_LU) begin
                        state_reg <= NFHC_READ;  // device streams from column
                    end else begin
                        state_reg <= NFHC_GAP;
                    end
                end
                NFHC_READ: begin
                    if (sync_pulse) begin
                        len_reg <= len_reg - 1'b1;
                        if (len_reg == 1) begin
                            state_reg <= NFHC_GAP;
                        end
                    end
                end
                NFHC_GAP: begin
                    last_prog_reg <= 1'b0;  // no program frames are issued here
                    rd_done       <= 1'b1;
                    state_reg     <= NFHC_DONE;
                end
                NFHC_DONE: begin
                    state_reg <= NFHC_IDLE;
                end
            endcase
        end
    end

    // status mirror: updated from bytes read after a status command; the sequential cache read command (31h) clears the ready bit
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            status_ready_bit       <= 1'b1;
            status_array_ready_bit <= 1'b1;
        end else if (clk_en) begin
            if (state_reg == NFHC_CMD1 && op_reg == NFHC_OP_CACHE_SEQ) begin
                status_ready_bit <= 1'b0;  // 31h leaves the unit busy
            end
            if (state_reg == NFHC_READ && sync_pulse && op_reg == NFHC_OP_STATUS) begin
                status_ready_bit       <= sync_data[`NFHC_SR_READY_POS];
                status_array_ready_bit <= sync_data[`NFHC_SR_ARRAY_POS];
            end
        end
    end

    // read data out to the user
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rd_valid <= 1'b0;
            rd_data  <= 8'h00;
        end else if (clk_en) begin
            rd_valid <= (state_reg == NFHC_READ) && sync_pulse;
            rd_data  <= sync_data;
        end
    end

    // write strobe engine: cle/ale select, we low then rising edge latches
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wbusy_reg <= 1'b0;
            phase_reg <= 2'h0;
            we_n      <= 1'b1;
            cle       <= 1'b0;
            ale       <= 1'b0;
            dq_out    <= 8'h00;
            dq_oe_n   <= 1'b1;
        end else if (clk_en) begin
            if (!wbusy_reg) begin
                phase_reg <= 2'h0;
                if (state_reg == NFHC_CMD1) begin
                    wbusy_reg <= 1'b1;
                    cle       <= 1'b1;
                    ale       <= 1'b0;
                    dq_oe_n   <= 1'b0;
                    unique case (op_reg)
                        NFHC_OP_CACHE_SEQ:  dq_out <= `NFHC_CMD_CACHE_SEQ;
                        NFHC_OP_CACHE_LAST: dq_out <= `NFHC_CMD_CACHE_LAST;
                        NFHC_OP_RAND_OUT:   dq_out <= `NFHC_CMD_RDOUT_1ST;
                        NFHC_OP_STATUS:     dq_out <= `NFHC_CMD_STATUS;
                        NFHC_OP_RESET:      dq_out <= `NFHC_CMD_RESET;
                        NFHC_OP_RESET_LU:   dq_out <= `NFHC_CMD_RESET_LU;
                        NFHC_OP_READ_ID:    dq_out <= `NFHC_CMD_READ_ID;
                        default:            dq_out <= `NFHC_CMD_READ_1ST;
                    endcase
                end else if (state_reg == NFHC_ADDR && addr_left_reg != 3'h0) begin
                    wbusy_reg <= 1'b1;
                    cle       <= 1'b0;
                    ale       <= 1'b1;
                    dq_out    <= addr_reg[7:0];
                    dq_oe_n   <= 1'b0;
                end else if (state_reg == NFHC_CMD2) begin
                    wbusy_reg <= 1'b1;
                    cle       <= 1'b1;
                    ale       <= 1'b0;
                    dq_out    <= cmd2_reg;
                    dq_oe_n   <= 1'b0;
                end else if (state_reg == NFHC_READ || state_reg == NFHC_WAIT) begin
                    cle     <= 1'b0;
                    ale     <= 1'b0;
                    dq_oe_n <= 1'b1;                                // release dq for reads
                end
            end else begin
                phase_reg <= phase_reg + 2'h1;
                we_n      <= !(phase_reg == 2'h0 || phase_reg == 2'h1);
                if (phase_reg == 2'h3) begin
                    wbusy_reg <= 1'b0;  // we rose at the end of phase 2
                end
            end
        end
    end

    // chip enable and the ce high gap after each frame
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ce_n         <= 1'b1;
            gap_reg      <= 16'h0;
            gap_done_reg <= 1'b0;
        end else if (clk_en) begin
            if (state_reg == NFHC_IDLE || state_reg == NFHC_DONE || state_reg == NFHC_GAP) begin
                ce_n <= 1'b1;
                if (gap_reg != 16'h0) begin
                    gap_reg      <= gap_reg - 16'h1;
                    gap_done_reg <= 1'b0;
                end else begin
                    gap_done_reg <= 1'b1;
                end
            end else begin
                ce_n         <= 1'b0;
                gap_done_reg <= 1'b0;
                gap_reg      <= last_prog_reg ? 16'(`NFHC_CE_HIGH_PROG_CYC)
                                              : 16'(`NFHC_CE_HIGH_READ_CYC);
            end
        end
    end

    // read strobe: one edge per byte, both edges carry data; the capture request
    // stands from the cycle after the edge until the byte has come back
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            read_strobe_n <= 1'b1;
            dq_capture    <= 1'b0;
            rd_step_reg   <= 2'h0;
        end else if (clk_en) begin
            if (state_reg == NFHC_READ && rd_step_reg == 2'h0) begin
                read_strobe_n <= !read_strobe_n;  // device puts out the next byte
                rd_step_reg   <= 2'h1;
            end else if (state_reg == NFHC_READ && rd_step_reg == 2'h1) begin
                dq_capture  <= 1'b1;  // byte has settled on dq_in
                rd_step_reg <= 2'h2;
            end else if (state_reg == NFHC_READ) begin
                if (sync_pulse) begin
                    dq_capture  <= 1'b0;
                    rd_step_reg <= 2'h0;
                end
            end else begin
                dq_capture    <= 1'b0;
                read_strobe_n <= 1'b1;
                rd_step_reg   <= 2'h0;
            end
        end
    end
endmodule
`default_nettype wire

// [logic/nfhc_pkg.sv]
// types shared by the flash host controller
package nfhc_pkg;
    // operations the user may launch
    typedef enum logic [3:0] {
        NFHC_OP_PAGE_READ  = 4'h0,
        NFHC_OP_HALF_READ  = 4'h1,
        NFHC_OP_CACHE_SEQ  = 4'h2,
        NFHC_OP_CACHE_LAST = 4'h3,
        NFHC_OP_RAND_OUT   = 4'h4,
        NFHC_OP_RESUME     = 4'h5,
        NFHC_OP_STATUS     = 4'h6,
        NFHC_OP_RESET      = 4'h7,
        NFHC_OP_RESET_LU   = 4'h8,
        NFHC_OP_READ_ID    = 4'h9
    } nfhc_op_t;
    // sequencer states, one-hot
    typedef enum logic [7:0] {
        NFHC_IDLE  = 8'h01,
        NFHC_CMD1  = 8'h02,
        NFHC_ADDR  = 8'h04,
        NFHC_CMD2  = 8'h08,
        NFHC_WAIT  = 8'h10,
        NFHC_READ  = 8'h20,
        NFHC_GAP   = 8'h40,
        NFHC_DONE  = 8'h80
    } nfhc_state_t;
endpackage

// [logic/nfhc_strobe_sync.sv]
// link-domain read strobe capture with a three-stage crossing back to the core
`timescale 1ns/1ps
`default_nettype none
module nfhc_strobe_sync
    import nfhc_pkg::*;
(
    input  wire logic       link_clock,
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       clk_en,
    input  wire logic [7:0] dq_in,
    input  wire logic       dq_capture,
    output logic      [7:0] data_out,
    output logic            data_pulse
);
    logic [7:0] held_reg;    // byte caught in the link domain
    logic       toggle_reg;  // flips once per byte caught
    logic [2:0] sync_reg;    // three-stage crossing of the toggle
    logic       seen_reg;    // last agreed toggle value
    logic [1:0] lrst_reg;    // reset carried into the link domain
    logic [2:0] req_reg;     // three-stage crossing of the capture request
    logic       req_seen_reg; // last agreed request level

    // link side: a request counts once stages two and three agree; its rise catches a byte
    always_ff @(posedge link_clock) begin
        lrst_reg <= {lrst_reg[0], reset_n};
        if (!lrst_reg[1]) begin
            req_reg      <= 3'h0;
            req_seen_reg <= 1'b0;
            toggle_reg   <= 1'b0;
        end else begin
            req_reg <= {req_reg[1:0], dq_capture};
            if (req_reg[1] == req_reg[2] && req_reg[2] != req_seen_reg) begin
                req_seen_reg <= req_reg[2];
                if (req_reg[2]) begin
                    held_reg   <= dq_in;
                    toggle_reg <= ~toggle_reg;
                end
            end
        end
    end

    // core side: three flops, a change counts once stages two and three agree
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sync_reg   <= 3'h0;
            seen_reg   <= 1'b0;
            data_out   <= 8'h00;
            data_pulse <= 1'b0;
        end else if (clk_en) begin
            sync_reg   <= {sync_reg[1:0], toggle_reg};
            data_pulse <= 1'b0;
            if (sync_reg[1] == sync_reg[2] && sync_reg[2] != seen_reg) begin
                seen_reg   <= sync_reg[2];
                data_out   <= held_reg;  // stable: toggle settled two cycles ago
                data_pulse <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [verif/nfhc_flash_model.sv]
// behavioural flash device answering the host pins
`timescale 1ns/1ps
`default_nettype none
module nfhc_flash_model (
    input  wire logic       ce_n,
    input  wire logic       cle,
    input  wire logic       ale,
    input  wire logic       we_n,
    input  wire logic       read_strobe_n,
    input  wire logic [7:0] dq_out,
    input  wire logic [7:0] status_val,
    output logic      [7:0] dq_in
);
    logic [7:0]  cmd_reg; // last command byte
    logic [15:0] col_reg; // latched column
    logic [2:0]  acnt;    // address bytes seen
    logic [7:0]  idx;     // bytes sent since the last command
    initial dq_in = 8'h5a;
    // latch on the write strobe rise
    always @(posedge we_n) begin
        if (!ce_n && cle) begin
            cmd_reg = dq_out;
            acnt = 3'h0;
            idx = 8'h00;
            if (dq_out inside {8'h31, 8'h3f, 8'hff}) col_reg = 16'h0000;
        end else if (!ce_n && ale) begin
            if (acnt == 3'h0) col_reg[7:0] = dq_out;
            if (acnt == 3'h1) col_reg[15:8] = dq_out;
            acnt = acnt + 3'h1;
        end
    end
    // one byte per strobe edge, status bytes after a status command
    always @(read_strobe_n) begin
        if (!ce_n && cmd_reg == 8'h70) dq_in = status_val;
        else if (!ce_n) begin
            dq_in = col_reg[7:0] + idx;
            idx = idx + 8'h01;
        end
    end
    // released bus shows no stale byte
    always @(posedge ce_n) dq_in = ~dq_in;
endmodule
`default_nettype wire

// [verif/nfhc_host_sva.sv]
// pin sequencing and refusal checks of the flash host
`timescale 1ns/1ps
`default_nettype none
module nfhc_host_sva
    import nfhc_pkg::*;
(
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       clk_en,
    input wire logic       op_valid,
    input wire nfhc_op_t   op_code,
    input wire logic       op_ready,
    input wire logic       op_refused,
    input wire logic       last_page_in_block,
    input wire logic       status_ready_bit,
    input wire logic       status_array_ready_bit,
    input wire logic       ce_n,
    input wire logic       cle,
    input wire logic       ale,
    input wire logic       we_n,
    input wire logic       read_strobe_n,
    input wire logic [7:0] dq_out,
    input wire logic       dq_oe_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    wire logic take;  // request accepted at this edge
    assign take = clk_en && op_valid && op_ready;
    a_we_needs_ce: assert property (!we_n |-> !ce_n && !dq_oe_n)
        else $error("write strobe without select or drive");
    a_latch_exclusive: assert property (!(cle && ale))
        else $error("command and address latch both high");
    a_read_mode_pins: assert property (!read_strobe_n |-> dq_oe_n && !cle && !ale)
        else $error("read strobe with latch or drive active");
    a_cmd_defined: assert property (!we_n && cle |-> dq_out inside {8'h00, 8'h30, 8'h20,
        8'h31, 8'h3f, 8'h05, 8'he0, 8'h70, 8'hff, 8'hfa, 8'h90})
        else $error("undefined command byte");
    a_ce_gap: assert property ($rose(ce_n) |=> ce_n [*3])
        else $error("select gap too short");
    a_cache_not_ready: assert property (take && op_code == NFHC_OP_CACHE_SEQ &&
        !status_ready_bit |=> op_refused) else $error("cache read taken while busy");
    a_cache_last_page: assert property (take && op_code == NFHC_OP_CACHE_SEQ &&
        last_page_in_block |=> op_refused) else $error("cache read past last page");
    a_array_busy: assert property (take && !status_array_ready_bit && op_code inside
        {NFHC_OP_PAGE_READ, NFHC_OP_HALF_READ, NFHC_OP_READ_ID} |=> op_refused)
        else $error("unrelated op taken while array busy");
endmodule
bind nfhc_host nfhc_host_sva u_sva (.clock, .reset_n, .clk_en, .op_valid, .op_code, .op_ready,
    .op_refused, .last_page_in_block, .status_ready_bit, .status_array_ready_bit, .ce_n,
    .cle, .ale, .we_n, .read_strobe_n, .dq_out, .dq_oe_n);
`default_nettype wire

// [verif/tb_nand_command_and_read_engine.sv]
// self-checking bench for the flash host sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_nand_command_and_read_engine
    import nfhc_pkg::*;
;
    logic        clock, link_clock, reset_n, clk_en, op_valid, last_page_in_block;
    nfhc_op_t    op_code;
    logic [15:0] op_column, op_length;
    logic [23:0] op_row;
    logic [7:0]  status_val, dq_in, dq_out, rd_data;
    logic        op_ready, op_refused, rd_valid, rd_done, status_ready_bit, dq_oe_n;
    logic        status_array_ready_bit, ce_n, cle, ale, we_n, read_strobe_n, dq_capture;
    int          n_fail, num_checks, cyc;
    nfhc_host DUT (.clock, .reset_n, .clk_en, .link_clock, .op_valid, .op_code, .op_column,
        .op_row, .op_length, .last_page_in_block, .op_ready, .op_refused, .rd_valid, .rd_data,
        .rd_done, .status_ready_bit, .status_array_ready_bit, .ce_n, .cle, .ale, .we_n,
        .read_strobe_n, .dq_out, .dq_oe_n, .dq_in, .dq_capture);
    nfhc_flash_model flash (.ce_n, .cle, .ale, .we_n, .read_strobe_n, .dq_out, .status_val, .dq_in);
    initial begin clock = 0; forever #5 clock = ~clock; end
    initial begin link_clock = 0; #1.7; forever #3 link_clock = ~link_clock; end
    // verdict and end of run
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin n_fail++; test_done; end
    end
    // one operation: request, collect bytes, judge refusal and data
    task automatic run_op(input nfhc_op_t c, input logic [15:0] col, input logic [15:0] len,
                          input logic [7:0] first, input logic refuse);
        logic [7:0] got[$];
        logic       seen;
        int         k;
        seen = 1'b0;
        @(posedge clock);
        #1;
        op_code = c;
        op_column = col;
        op_length = len;
        op_valid = 1'b1;
        k = 0;
        while (op_ready !== 1'b1 && k < 300) begin @(posedge clock); #1; k++; end
        @(posedge clock);
        #1;
        op_valid = 1'b0;
        for (k = 0; k < 900; k++) begin
            if (rd_valid === 1'b1) got.push_back(rd_data);
            seen |= (op_refused === 1'b1);
            if (seen || rd_done === 1'b1) break;
            @(posedge clock);
            #1;
        end
        `CHK(k < 900, 1'b1)
        `CHK(seen, refuse)
        if (!refuse) begin
            `CHK(got.size(), int'(len))
            foreach (got[i]) `CHK(got[i], first + 8'(i))
        end
    endtask
    task automatic t_page_read;
        run_op(NFHC_OP_PAGE_READ, 16'h0010, 16'h0004, 8'h10, 1'b0);
        run_op(NFHC_OP_RAND_OUT, 16'h0040, 16'h0003, 8'h40, 1'b0);
        run_op(NFHC_OP_STATUS, 16'h0000, 16'h0001, 8'h60, 1'b0);
        run_op(NFHC_OP_RESUME, 16'h0000, 16'h0002, 8'h40, 1'b0);
        $display("test page_read done");
    endtask
    task automatic t_cache;
        run_op(NFHC_OP_CACHE_SEQ, 16'h0000, 16'h0002, 8'h00, 1'b0);
        run_op(NFHC_OP_CACHE_SEQ, 16'h0000, 16'h0002, 8'h00, 1'b1);
        run_op(NFHC_OP_STATUS, 16'h0000, 16'h0001, 8'h60, 1'b0);
        `CHK(status_ready_bit, 1'b1)
        last_page_in_block = 1'b1;
        run_op(NFHC_OP_CACHE_SEQ, 16'h0000, 16'h0002, 8'h00, 1'b1);
        last_page_in_block = 1'b0;
        run_op(NFHC_OP_CACHE_LAST, 16'h0000, 16'h0002, 8'h00, 1'b0);
        $display("test cache done");
    endtask
    task automatic t_busy;
        status_val = 8'h40;
        run_op(NFHC_OP_STATUS, 16'h0000, 16'h0001, 8'h40, 1'b0);
        `CHK(status_array_ready_bit, 1'b0)
        run_op(NFHC_OP_READ_ID, 16'h0000, 16'h0001, 8'h00, 1'b1);
        status_val = 8'h60;
        run_op(NFHC_OP_STATUS, 16'h0000, 16'h0001, 8'h60, 1'b0);
        $display("test busy done");
    endtask
    task automatic t_half_reset;
        run_op(NFHC_OP_HALF_READ, 16'h1180, 16'h0002, 8'h80, 1'b0);
        run_op(NFHC_OP_PAGE_READ, 16'h0021, 16'h0002, 8'h20, 1'b0);
        run_op(NFHC_OP_RESET_LU, 16'h0000, 16'h0000, 8'h00, 1'b0);
        run_op(NFHC_OP_RESET, 16'h0000, 16'h0000, 8'h00, 1'b0);
        $display("test half_reset done");
    endtask
    initial begin
        {reset_n, op_valid, last_page_in_block, op_column, op_length} = '0;
        {n_fail, num_checks, cyc} = '0;
        clk_en = 1'b1;
        op_code = NFHC_OP_STATUS;
        op_row = 24'h000123;
        status_val = 8'h60;
        repeat (8) @(posedge clock);
        `CHK({ce_n, we_n, dq_oe_n, op_ready}, 4'he)
        #1 reset_n = 1'b1;
        t_page_read;
        t_cache;
        t_busy;
        t_half_reset;
        test_done;
    end
endmodule
`default_nettype wire
